// ### adc_seq_defs.svh
// constants for the converter sequencer control block
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define ADR_CTRL1 4'h0
`define ADR_CTRL2 4'h1
`define ADR_RSQ0 4'h2
`define ADR_RSQ1 4'h3
`define ADR_RSQ2 4'h4
`define ADR_JSQ 4'h5
`define ADR_STAT 4'h6
`define ADR_RRES 4'h7
`define ADR_JRES 4'h8
`define ADR_HIGH 4'h9
`define ADR_LOW 4'ha
`define CONV_CYCLES 5'h0e
`define STAB_NS 1000
`define CLK_NS 25
`define STAB_CYCLES ((`STAB_NS + `CLK_NS - 1) / `CLK_NS)
`define HIGH_RST 12'hfff
`define LOW_RST 12'h000
`define B_CH_PICK 4:0
`define B_IRQ_R 5
`define B_IRQ_J 6
`define B_IRQ_W 7
`define B_SWEEP 8
`define B_ONE_CH 9
`define B_AUTO 10
`define B_MON_J 22
`define B_MON_R 23
`define B_PWR 0
`define B_REPEAT 1
`define B_XDMA 8
`define B_RTRG_EN 20
`define B_JTRG_EN 15
`define B_RATIO2 31
`define B_F_W 0
`define B_F_R 1
`define B_F_J 2
`endif

// ### adc_seq_pkg.sv
// types for the converter sequencer control block
package adc_seq_pkg;
	typedef enum logic [2:0] {S_OFF, S_WAKE, S_READY, S_CONV, S_GAP} seq_state_e;
	typedef logic [4:0] chan_t;
endpackage : adc_seq_pkg

// ### adc_edge_sync.sv
// two-flop synchroniser with rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module adc_edge_sync (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_async,
	output logic o_rise
);
	logic [2:0] sync_q;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync_q <= 3'h0;
		end else begin
			sync_q <= {sync_q[1:0], i_async};
		end
	end
	assign o_rise = sync_q[1] & ~sync_q[2];
endmodule : adc_edge_sync
`default_nettype wire

// ### adc_sequencer_control.sv
// sequencer control for a successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defs.svh"
module adc_sequencer_control (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_reg_trig,
	input wire logic i_pri_trig,
	input wire logic [11:0] i_conv_data,
	output logic o_sample,
	output logic [4:0] o_channel,
	output logic o_power,
	output logic o_irq,
	output logic o_dma_req
);
	// converter_clock is i_clk_sys, synchronous to the bus clock
	logic [31:0] ctrl1_q;
	logic [31:0] ctrl2_q;
	logic [29:0] rsq_q [0:2];
	logic [31:0] jsq_q;
	logic [11:0] high_q;
	logic [11:0] low_q;
	logic [15:0] rres_q;
	logic [15:0] jres_q;
	logic [2:0] flag_q;
	logic [31:0] rdata_q;
	logic dma_q;
	adc_seq_pkg::seq_state_e state_q;
	adc_seq_pkg::seq_state_e state_d;
	logic [15:0] stab_q;
	logic [4:0] cyc_q;
	logic [1:0] gap_q;
	logic [3:0] ridx_q;
	logic [1:0] jidx_q;
	logic inj_q;
	logic rpend_q;
	logic rsus_q;
	logic [3:0] rlen;
	logic [1:0] jlen;
	logic reg_rise;
	logic pri_rise;
	adc_edge_sync u_rsync (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_async(i_reg_trig),
		.o_rise(reg_rise)
	);
	adc_edge_sync u_jsync (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_async(i_pri_trig),
		.o_rise(pri_rise)
	);
	function automatic adc_seq_pkg::chan_t reg_entry(input logic [29:0] w0,
		input logic [29:0] w1, input logic [29:0] w2, input logic [3:0] idx);
		logic [29:0] w;
		w = (idx < 4'h6) ? w0 : (idx < 4'hc) ? w1 : w2;
		case (idx)
			4'h0, 4'h6, 4'hc: reg_entry = w[4:0];
			4'h1, 4'h7, 4'hd: reg_entry = w[9:5];
			4'h2, 4'h8, 4'he: reg_entry = w[14:10];
			4'h3, 4'h9, 4'hf: reg_entry = w[19:15];
			4'h4, 4'ha: reg_entry = w[24:20];
			default: reg_entry = w[29:25];
		endcase
	endfunction : reg_entry
	wire wr_ctrl2 = i_wr && (i_addr == `ADR_CTRL2);
	wire pwr_set = wr_ctrl2 && i_wdata[`B_PWR];
	wire pwr_clr = wr_ctrl2 && !i_wdata[`B_PWR];
	wire seq_wr = i_wr && (i_addr == `ADR_RSQ0 || i_addr == `ADR_RSQ1 ||
		i_addr == `ADR_RSQ2 || i_addr == `ADR_JSQ);
	wire sweep = ctrl1_q[`B_SWEEP];
	wire auto_f = ctrl1_q[`B_AUTO];
	wire repeat_m = ctrl2_q[`B_REPEAT];
	assign rlen = rsq_q[2][23:20];
	assign jlen = jsq_q[21:20];
	// an injected trigger is ignored under auto follow
	wire jtrig = pri_rise && ctrl2_q[`B_JTRG_EN] && !auto_f;
	wire rtrig = reg_rise && ctrl2_q[`B_RTRG_EN];
	wire rstart = rtrig || (pwr_set && state_q == adc_seq_pkg::S_READY);
	wire conv_done = (state_q == adc_seq_pkg::S_CONV) && (cyc_q == `CONV_CYCLES - 5'h1);
	wire inj_now = (state_q == adc_seq_pkg::S_CONV) && !inj_q && jtrig && sweep;
	// entry selection: channels 16 and 17 are internal sources
	wire [4:0] rchan = reg_entry(rsq_q[0], rsq_q[1], rsq_q[2], ridx_q);
	wire [4:0] jchan = (jidx_q == 2'h0) ? jsq_q[4:0] : (jidx_q == 2'h1) ? jsq_q[9:5] :
		(jidx_q == 2'h2) ? jsq_q[14:10] : jsq_q[19:15];
	wire [4:0] cur_chan = inj_q ? jchan : rchan;
	wire r_last = ridx_q == rlen;
	wire j_last = jidx_q == jlen;
	// window check on raw data, justification not applied
	wire out_win = (i_conv_data < low_q) || (i_conv_data > high_q);
	wire guard_grp = inj_q ? ctrl1_q[`B_MON_J] : ctrl1_q[`B_MON_R];
	wire guard_ch = !ctrl1_q[`B_ONE_CH] || (cur_chan == ctrl1_q[`B_CH_PICK]);
	wire win_hit = conv_done && guard_grp && guard_ch && out_win;
	// group advance decisions at the end of a conversion
	wire r_more = sweep && !r_last;
	wire j_more = sweep && !j_last;
	wire go_inj_auto = !inj_q && r_last && auto_f;
	wire inj_end = inj_q && (!j_more);
	wire [1:0] gap_len = ctrl2_q[`B_RATIO2] ? 2'h2 : 2'h1;
	always_comb begin
		state_d = state_q;
		case (state_q)
			adc_seq_pkg::S_OFF: if (pwr_set) state_d = adc_seq_pkg::S_WAKE;
			adc_seq_pkg::S_WAKE: if (stab_q == 16'h0) state_d = adc_seq_pkg::S_READY;
			adc_seq_pkg::S_READY: begin
				if (rstart || (jtrig && sweep) || rpend_q) state_d = adc_seq_pkg::S_CONV;
			end
			adc_seq_pkg::S_CONV: begin
				if (conv_done) begin
					if (inj_q) begin
						if (j_more) state_d = adc_seq_pkg::S_CONV;
						else if (auto_f && repeat_m) state_d = adc_seq_pkg::S_GAP;
						else if (rpend_q || rsus_q) state_d = adc_seq_pkg::S_CONV;
						else state_d = adc_seq_pkg::S_READY;
					end else if (go_inj_auto) begin
						state_d = adc_seq_pkg::S_GAP;
					end else if (r_more || repeat_m) begin
						state_d = adc_seq_pkg::S_CONV;
					end else begin
						state_d = adc_seq_pkg::S_READY;
					end
				end
			end
			adc_seq_pkg::S_GAP: if (gap_q == 2'h1) state_d = adc_seq_pkg::S_CONV;
			default: state_d = adc_seq_pkg::S_OFF;
		endcase
		if (pwr_clr) state_d = adc_seq_pkg::S_OFF;
	end
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= adc_seq_pkg::S_OFF;
			stab_q <= 16'h0;
			gap_q <= 2'h0;
		end else begin
			state_q <= state_d;
			if (state_q == adc_seq_pkg::S_OFF) stab_q <= 16'(`STAB_CYCLES);
			else if (stab_q != 16'h0) stab_q <= stab_q - 16'h1;
			if (state_q != adc_seq_pkg::S_GAP) gap_q <= gap_len;
			else gap_q <= gap_q - 2'h1;
		end
	end
	// conversion timer: restarts on start, abort or sequence write
	wire conv_restart = (state_q != adc_seq_pkg::S_CONV) || conv_done || inj_now || seq_wr;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cyc_q <= 5'h0;
		end else if (conv_restart) begin
			cyc_q <= 5'h0;
		end else begin
			cyc_q <= cyc_q + 5'h1;
		end
	end
	// group position, injection bookkeeping
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ridx_q <= 4'h0;
			jidx_q <= 2'h0;
			inj_q <= 1'b0;
			rsus_q <= 1'b0;
		end else if (state_q == adc_seq_pkg::S_OFF) begin
			ridx_q <= 4'h0;
			jidx_q <= 2'h0;
			inj_q <= 1'b0;
			rsus_q <= 1'b0;
		end else if (state_q == adc_seq_pkg::S_READY) begin
			inj_q <= jtrig && sweep;
			jidx_q <= 2'h0;
			rsus_q <= 1'b0;
			if (!(jtrig && sweep)) ridx_q <= 4'h0;
		end else if (inj_now) begin
			inj_q <= 1'b1;
			jidx_q <= 2'h0;
			// remembers that a regular group was cut and must resume
			rsus_q <= 1'b1;
		end else if (conv_done) begin
			if (inj_q) begin
				if (j_more) begin
					jidx_q <= jidx_q + 2'h1;
				end else begin
					inj_q <= 1'b0;
					jidx_q <= 2'h0;
					rsus_q <= 1'b0;
					// a cut regular group resumes at the aborted entry
					if (auto_f || (rpend_q && !rsus_q)) ridx_q <= 4'h0;
				end
			end else if (go_inj_auto) begin
				inj_q <= 1'b1;
				jidx_q <= 2'h0;
			end else if (sweep) begin
				ridx_q <= r_last ? 4'h0 : ridx_q + 4'h1;
			end
		end else if (seq_wr && state_q == adc_seq_pkg::S_CONV) begin
			if (inj_q) jidx_q <= 2'h0;
			else ridx_q <= 4'h0;
		end
	end
	// a regular trigger during an injected sequence waits for its end
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rpend_q <= 1'b0;
		end else if (state_q == adc_seq_pkg::S_OFF || state_q == adc_seq_pkg::S_READY) begin
			rpend_q <= 1'b0;
		end else if (state_q == adc_seq_pkg::S_CONV && inj_q && rtrig) begin
			rpend_q <= 1'b1;
		end else if (conv_done && inj_end) begin
			rpend_q <= 1'b0;
		end
	end
	// results, flags and transfer request
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rres_q <= 16'h0;
			jres_q <= 16'h0;
			flag_q <= 3'h0;
			dma_q <= 1'b0;
		end else begin
			dma_q <= conv_done && !inj_q && ctrl2_q[`B_XDMA];
			if (conv_done && !inj_q) rres_q <= {4'h0, i_conv_data};
			if (conv_done && inj_q) jres_q <= {4'h0, i_conv_data};
			// set wins over a software clear in the same cycle
			if (i_wr && i_addr == `ADR_STAT) flag_q <= flag_q & i_wdata[2:0];
			if (win_hit) flag_q[`B_F_W] <= 1'b1;
			if (conv_done && !inj_q) flag_q[`B_F_R] <= 1'b1;
			if (conv_done && inj_q) flag_q[`B_F_J] <= 1'b1;
		end
	end
	// register writes
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl1_q <= 32'h0;
			ctrl2_q <= 32'h0;
			rsq_q[0] <= 30'h0;
			rsq_q[1] <= 30'h0;
			rsq_q[2] <= 30'h0;
			jsq_q <= 32'h0;
			high_q <= `HIGH_RST;
			low_q <= `LOW_RST;
		end else if (i_wr) begin
			case (i_addr)
				`ADR_CTRL1: ctrl1_q <= i_wdata;
				`ADR_CTRL2: ctrl2_q <= i_wdata;
				`ADR_RSQ0: rsq_q[0] <= i_wdata[29:0];
				`ADR_RSQ1: rsq_q[1] <= i_wdata[29:0];
				`ADR_RSQ2: rsq_q[2] <= i_wdata[29:0];
				`ADR_JSQ: jsq_q <= {10'h0, i_wdata[21:0]};
				`ADR_HIGH: high_q <= i_wdata[11:0];
				`ADR_LOW: low_q <= i_wdata[11:0];
				default: ;
			endcase
		end
	end
	// register reads, answer one cycle later, unmapped reads zero
	wire [31:0] rd_mux = (i_addr == `ADR_CTRL1) ? ctrl1_q :
		(i_addr == `ADR_CTRL2) ? ctrl2_q :
		(i_addr == `ADR_RSQ0) ? {2'h0, rsq_q[0]} :
		(i_addr == `ADR_RSQ1) ? {2'h0, rsq_q[1]} :
		(i_addr == `ADR_RSQ2) ? {2'h0, rsq_q[2]} :
		(i_addr == `ADR_JSQ) ? jsq_q :
		(i_addr == `ADR_STAT) ? {26'h0, 3'(state_q), flag_q} :
		(i_addr == `ADR_RRES) ? {16'h0, rres_q} :
		(i_addr == `ADR_JRES) ? {16'h0, jres_q} :
		(i_addr == `ADR_HIGH) ? {20'h0, high_q} :
		(i_addr == `ADR_LOW) ? {20'h0, low_q} : 32'h0;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= i_rd ? rd_mux : 32'h0;
		end
	end
	assign o_rdata = rdata_q;
	assign o_dma_req = dma_q;
	assign o_sample = (state_q == adc_seq_pkg::S_CONV) && (cyc_q == 5'h0);
	assign o_channel = cur_chan;
	assign o_power = state_q != adc_seq_pkg::S_OFF;
	assign o_irq = (flag_q[`B_F_R] && ctrl1_q[`B_IRQ_R]) ||
		(flag_q[`B_F_J] && ctrl1_q[`B_IRQ_J]) ||
		(flag_q[`B_F_W] && ctrl1_q[`B_IRQ_W]);
	sequence s_inj_last;
		conv_done && inj_end && !pwr_clr;
	endsequence
	a_done_timing: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		conv_done |-> $past(o_sample, 13))
		else $error("conversion did not finish at fourteen cycles");
	a_reg_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		conv_done && !inj_q |=> flag_q[`B_F_R] && rres_q[11:0] == $past(i_conv_data))
		else $error("regular result or flag missing");
	a_pri_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		conv_done && inj_q |=> flag_q[`B_F_J] && jres_q[11:0] == $past(i_conv_data))
		else $error("injected result or flag missing");
	a_dma_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_dma_req |-> $past(conv_done && !inj_q && ctrl2_q[`B_XDMA]))
		else $error("transfer request without regular result");
	a_win_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		win_hit |=> flag_q[`B_F_W])
		else $error("window flag not set");
	a_flag_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		flag_q[`B_F_R] && !(i_wr && i_addr == `ADR_STAT) |=> flag_q[`B_F_R])
		else $error("done flag dropped without clear");
	a_gap_len: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		state_q != adc_seq_pkg::S_GAP ##1 state_q == adc_seq_pkg::S_GAP && !ctrl2_q[`B_RATIO2]
		|=> state_q != adc_seq_pkg::S_GAP)
		else $error("gap longer than one clock");
	a_off_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		pwr_clr |=> !o_power)
		else $error("power bit clear did not power down");
	a_inj_abort: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		inj_now |=> inj_q && cyc_q == 5'h0)
		else $error("injected trigger did not abort");
	a_reg_resume: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		s_inj_last ##0 (rsus_q || rpend_q) && !(auto_f && repeat_m)
		|=> state_q == adc_seq_pkg::S_CONV && !inj_q)
		else $error("regular group did not follow the injected sequence");
	a_reg_defer: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		state_q == adc_seq_pkg::S_CONV && inj_q && rtrig |=> rpend_q)
		else $error("regular trigger during injection was lost");
endmodule : adc_sequencer_control
`default_nettype wire

// ### adc_core_model.sv
// analog core stand-in returning channel-tagged raw results
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
	input wire logic i_clk_sys,
	input wire logic i_power,
	input wire logic i_sample,
	input wire logic [4:0] i_channel,
	input wire logic [6:0] i_level,
	output logic [11:0] o_data
);
	logic [4:0] chan_q = 5'h00;
	logic [11:0] idle_q = 12'h5a5;
	// channel is latched when sampling starts
	always_ff @(posedge i_clk_sys) begin
		if (i_sample) begin
			chan_q <= i_channel;
		end
		idle_q <= ~idle_q;
	end
	// a powered-down core leaves the data lines wandering
	assign o_data = i_power ? {chan_q, i_level} : idle_q;
endmodule : adc_core_model
`default_nettype wire

// ### tb.sv
// self-checking bench for the converter sequencer control
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defs.svh"
module tb;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_reg_trig = 1'b0;
	logic i_pri_trig = 1'b0;
	logic [6:0] level = 7'h2a;
	logic [11:0] i_conv_data;
	logic [31:0] o_rdata;
	logic o_sample, o_power, o_irq, o_dma_req, irq_prev;
	logic [4:0] o_channel;
	logic [31:0] rv, cfg[6];
	logic [6:0] lv[6];
	logic ex[6];
	logic [4:0] seen[$], e16[$];
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	int t_irq = 0;
	int n_dma = 0;
	int st[$];
	localparam logic [31:0] C2 = (32'h1 << `B_PWR) | (32'h1 << `B_XDMA);
	always #12.5 i_clk_sys = ~i_clk_sys;
	adc_sequencer_control i_adc_sequencer_control (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_reg_trig(i_reg_trig), .i_pri_trig(i_pri_trig), .i_conv_data(i_conv_data),
		.o_sample(o_sample), .o_channel(o_channel), .o_power(o_power), .o_irq(o_irq),
		.o_dma_req(o_dma_req));
	adc_core_model i_adc_core_model (.i_clk_sys(i_clk_sys), .i_power(o_power),
		.i_sample(o_sample), .i_channel(o_channel), .i_level(level), .o_data(i_conv_data));
	// records each conversion start, transfer request and interrupt rise
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		irq_prev <= o_irq;
		if (o_sample === 1'b1) begin
			seen.push_back(o_channel);
			st.push_back(cyc);
		end
		if (o_dma_req === 1'b1)
			n_dma <= n_dma + 1;
		if (o_irq === 1'b1 && irq_prev !== 1'b1)
			t_irq <= cyc;
	end
	function automatic logic [31:0] bv(input int b);
		return 32'h1 << b;
	endfunction : bv
	task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
		cmp_count++;
		if (seen_v !== exp_v) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen_v, exp_v);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd
	task automatic start(input logic [31:0] c2);
		seen.delete();
		st.delete();
		n_dma = 0;
		wr(`ADR_CTRL2, c2);
	endtask : start
	task automatic wait_n(input int n);
		int k;
		k = 0;
		while (seen.size() < n && k < 3000) begin
			@(posedge i_clk_sys);
			k++;
		end
		if (k >= 3000) begin
			n_fail++;
			report_and_stop();
		end else begin
			repeat (40) @(posedge i_clk_sys);
		end
	endtask : wait_n
	task automatic chk_seq(input logic [4:0] e[$]);
		chk(32'(seen.size()), 32'(e.size()));
		foreach (e[i]) chk({27'h0, seen[i]}, {27'h0, e[i]});
	endtask : chk_seq
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		for (int i = 0; i < 16; i++) e16.push_back(5'(i % 6 + 1));
		cfg = '{32'h0, bv(`B_MON_R), bv(`B_MON_R) | bv(`B_ONE_CH),
			bv(`B_MON_R) | bv(`B_ONE_CH) | 32'h3, bv(`B_MON_J), bv(`B_MON_R) | bv(`B_ONE_CH)};
		lv = '{7'h20, 7'h20, 7'h20, 7'h20, 7'h20, 7'h05};
		ex = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		repeat (6) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		rd(`ADR_HIGH, rv);
		chk(rv, 32'h0000_0fff);
		rd(`ADR_LOW, rv);
		chk(rv, 32'h0);
		rd(`ADR_STAT, rv);
		chk(rv, 32'h0);
		rd(4'hf, rv);
		chk(rv, 32'h0);
		wr(`ADR_CTRL2, C2);
		repeat (30) @(posedge i_clk_sys);
		chk({31'h0, o_power}, 32'h1);
		chk(32'(seen.size()), 32'h0);
		repeat (20) @(posedge i_clk_sys);
		wr(`ADR_CTRL1, bv(`B_IRQ_R) | bv(`B_IRQ_J) | bv(`B_IRQ_W));
		wr(`ADR_RSQ0, 32'd16);
		wr(`ADR_RSQ2, 32'h0);
		start(C2);
		wait_n(1);
		chk_seq('{5'd16});
		chk(32'(t_irq - st[0]), 32'd14);
		chk(32'(n_dma), 32'd1);
		rd(`ADR_RRES, rv);
		chk(rv, {20'h0, 5'd16, level});
		rd(`ADR_STAT, rv);
		chk({31'h0, rv[`B_F_R]}, 32'h1);
		chk({31'h0, o_irq}, 32'h1);
		wr(`ADR_STAT, 32'h0);
		rd(`ADR_STAT, rv);
		chk(rv & 32'h7, 32'h0);
		chk({31'h0, o_irq}, 32'h0);
		wr(`ADR_CTRL1, bv(`B_SWEEP));
		wr(`ADR_RSQ0, 32'h0c52_0c41);
		wr(`ADR_RSQ1, 32'h0c52_0c41);
		wr(`ADR_RSQ2, 32'h00f2_0c41);
		start(C2);
		wait_n(16);
		chk_seq(e16);
		chk(32'(n_dma), 32'd16);
		wr(`ADR_HIGH, 32'h100);
		wr(`ADR_LOW, 32'h010);
		wr(`ADR_RSQ0, 32'd3 << 5);
		wr(`ADR_RSQ2, 32'd1 << 20);
		for (int i = 0; i < 6; i++) begin
			level = lv[i];
			wr(`ADR_STAT, 32'h0);
			wr(`ADR_CTRL1, bv(`B_SWEEP) | bv(`B_IRQ_W) | cfg[i]);
			start(C2);
			wait_n(2);
			rd(`ADR_STAT, rv);
			chk({31'h0, rv[`B_F_W]}, {31'h0, ex[i]});
			chk({31'h0, o_irq}, {31'h0, ex[i]});
		end
		wr(`ADR_STAT, 32'h0);
		wr(`ADR_CTRL1, 32'h0);
		wr(`ADR_RSQ2, 32'h0);
		wr(`ADR_RSQ0, 32'd5);
		start(C2);
		repeat (4) @(posedge i_clk_sys);
		wr(`ADR_RSQ0, 32'd9);
		wait_n(2);
		chk_seq('{5'd5, 5'd9});
		chk(32'(n_dma), 32'd1);
		wr(`ADR_CTRL1, bv(`B_SWEEP) | bv(`B_IRQ_J));
		wr(`ADR_RSQ0, 32'd1 | 32'd2 << 5 | 32'd3 << 10);
		wr(`ADR_RSQ2, 32'd2 << 20);
		wr(`ADR_JSQ, 32'd7);
		start(C2 | bv(`B_JTRG_EN) | bv(`B_RTRG_EN));
		repeat (3) @(posedge i_clk_sys);
		i_pri_trig <= 1'b1;
		wait_n(5);
		i_pri_trig <= 1'b0;
		chk_seq('{5'd1, 5'd7, 5'd1, 5'd2, 5'd3});
		chk(32'(n_dma), 32'd3);
		rd(`ADR_JRES, rv);
		chk(rv, {20'h0, 5'd7, level});
		rd(`ADR_STAT, rv);
		chk({31'h0, rv[`B_F_J]}, 32'h1);
		chk({31'h0, o_irq}, 32'h1);
		seen.delete();
		st.delete();
		n_dma = 0;
		@(posedge i_clk_sys);
		i_pri_trig <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		i_reg_trig <= 1'b1;
		wait_n(4);
		i_pri_trig <= 1'b0;
		i_reg_trig <= 1'b0;
		chk_seq('{5'd7, 5'd1, 5'd2, 5'd3});
		chk(32'(n_dma), 32'd3);
		wr(`ADR_CTRL1, bv(`B_SWEEP) | bv(`B_AUTO));
		wr(`ADR_RSQ0, 32'd4);
		wr(`ADR_RSQ2, 32'h0);
		wr(`ADR_JSQ, 32'd17);
		for (int r = 0; r < 2; r++) begin
			start(C2 | (r == 1 ? bv(`B_RATIO2) : 32'h0));
			wait_n(2);
			chk_seq('{5'd4, 5'd17});
			chk(32'(st[1] - st[0]), 32'd15 + 32'(r));
		end
		wr(`ADR_CTRL1, 32'h0);
		wr(`ADR_RSQ0, 32'd5);
		start(C2 | bv(`B_REPEAT));
		wait_n(3);
		chk(32'(st[1] - st[0]), 32'd14);
		chk(32'(st[2] - st[1]), 32'd14);
		wr(`ADR_CTRL2, 32'h0);
		repeat (2) @(posedge i_clk_sys);
		#1;
		chk({31'h0, o_power}, 32'h0);
		n_dma = seen.size();
		repeat (30) @(posedge i_clk_sys);
		chk(32'(seen.size()), 32'(n_dma));
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
